// ==== hw/fsr_consts.svh ====
// Constants of the flash status and reset sequencer: offsets, fields, timings.
// Assumes a 250 MHz system clock; included by bare name.
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define FSR_OFF_CTRL 6'h00
`define FSR_OFF_ADDR 6'h04
`define FSR_OFF_WDATA 6'h08
`define FSR_OFF_RDATA 6'h0C
`define FSR_OFF_STATUS 6'h10
`define FSR_OFF_VPP 6'h14
`define FSR_OFF_IRQ_STAT 6'h18
`define FSR_OFF_IRQ_CLR 6'h1C
`define FSR_OFF_IRQ_EN 6'h20
// ----------------------------------------
// Fields and response codes
// ----------------------------------------
`define FSR_CTRL_OP_LSB 0
`define FSR_CTRL_SUSP_BIT 4
`define FSR_CTRL_RES_BIT 5
`define FSR_SR_GLOBAL_BIT 15
`define FSR_SR_PART_BIT 7
`define FSR_IRQ_DONE_BIT 0
`define FSR_IRQ_ERR_BIT 1
`define FSR_RESP_OKAY 2'h0
`define FSR_RESP_SLVERR 2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define FSR_CLK_PS 4000
`define FSR_NS_CYC(ns) ((((ns) * 1000) + `FSR_CLK_PS - 1) / `FSR_CLK_PS)
`define FSR_US_CYC(us) ((((us) * 1000000) + `FSR_CLK_PS - 1) / `FSR_CLK_PS)
`define FSR_T_WP_NS 50
`define FSR_T_WPH_NS 30
`define FSR_T_AVQV_NS 80
`define FSR_T_SETTLE_NS (`FSR_T_AVQV_NS + 100)
`define FSR_T_RST_LOW_NS 100
`define FSR_T_PHQV_NS 150
`define FSR_T_ABORT_US 22
`define FSR_T_ERES_US 500
`define FSR_WP_CYC `FSR_NS_CYC(`FSR_T_WP_NS)
`define FSR_WPH_CYC `FSR_NS_CYC(`FSR_T_WPH_NS)
`define FSR_ACC_CYC `FSR_NS_CYC(`FSR_T_AVQV_NS)
`define FSR_SETTLE_CYC `FSR_NS_CYC(`FSR_T_SETTLE_NS)
`define FSR_RST_LOW_CYC `FSR_NS_CYC(`FSR_T_RST_LOW_NS)
`define FSR_PHQV_CYC `FSR_NS_CYC(`FSR_T_PHQV_NS)
`define FSR_ABORT_CYC `FSR_US_CYC(`FSR_T_ABORT_US)
`define FSR_ERES_CYC `FSR_US_CYC(`FSR_T_ERES_US)
`endif

// ==== hw/fsr_pkg.sv ====
// Types of the flash status and reset sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package fsr_pkg;
   // ----------------------------------------
   // Commands and states
   // ----------------------------------------
   typedef enum logic [2:0] {
      FSR_OP_NONE = 3'h0,
      FSR_OP_WRITE = 3'h1,
      FSR_OP_READ = 3'h2,
      FSR_OP_WRITE_POLL = 3'h3,
      FSR_OP_RESET = 3'h4,
      FSR_OP_POLL = 3'h5
   } fsr_op_t;
   typedef enum logic [4:0] {
      FSR_CY_IDLE = 5'h01,
      FSR_CY_WSET = 5'h02,
      FSR_CY_WLOW = 5'h04,
      FSR_CY_RLOW = 5'h08,
      FSR_CY_GAP = 5'h10
   } fsr_cyc_st_t;
   typedef enum logic [7:0] {
      FSR_S_RSTLO = 8'h01,
      FSR_S_RSTREC = 8'h02,
      FSR_S_IDLE = 8'h04,
      FSR_S_GAPW = 8'h08,
      FSR_S_WR = 8'h10,
      FSR_S_SETTLE = 8'h20,
      FSR_S_POLL = 8'h40,
      FSR_S_RD = 8'h80
   } fsr_seq_st_t;
endpackage

// ==== hw/fsr_cyc_if.sv ====
// Request and answer between the sequencer and the flash bus cycle engine.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface fsr_cyc_if #(parameter int ADDR_W = 22);
   logic req;
   logic wr;
   logic [ADDR_W-1:0] addr;
   logic [15:0] wdata;
   logic ack;
   logic [15:0] rdata;
   modport master(output req, wr, addr, wdata, input ack, rdata);
   modport slave(input req, wr, addr, wdata, output ack, rdata);
endinterface

// ==== hw/fsr_cyc.sv ====
// Flash bus cycle engine: one strobed write or read per request.
// Assumes req holds until ack and flash inputs are synchronous to sys_clk_i.
`timescale 1ns/100ps
`include "fsr_consts.svh"
module fsr_cyc import fsr_pkg::*; #(
   parameter int ADDR_W = 22
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // Sequencer side
   fsr_cyc_if.slave cyc,
   // Flash pins
   output logic [ADDR_W-1:0] fl_addr_o,
   input wire logic [15:0] fl_dq_i,
   output logic [15:0] fl_dq_o,
   output logic fl_dq_oe_n_o,
   output logic fl_ce_n_o,
   output logic fl_we_n_o,
   output logic fl_oe_n_o
);
   fsr_cyc_st_t st;
   logic [7:0] cnt;
   wire cnt_done = (cnt == 8'h00);
   wire go = cyc.req && !cyc.ack;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st <= FSR_CY_IDLE;
         cnt <= 8'h00;
         cyc.ack <= 1'b0;
         cyc.rdata <= 16'h0000;
         fl_addr_o <= '0;
         fl_dq_o <= 16'h0000;
         fl_dq_oe_n_o <= 1'b1;
         fl_ce_n_o <= 1'b1;
         fl_we_n_o <= 1'b1;
         fl_oe_n_o <= 1'b1;
      end else begin
         cyc.ack <= 1'b0;
         case (st)
            FSR_CY_IDLE: begin
               if (go) begin
                  fl_addr_o <= cyc.addr;
                  fl_ce_n_o <= 1'b0;
                  if (cyc.wr) begin
                     fl_dq_o <= cyc.wdata;
                     fl_dq_oe_n_o <= 1'b0;
                     st <= FSR_CY_WSET;
                  end else begin
                     fl_oe_n_o <= 1'b0;
                     cnt <= 8'(`FSR_ACC_CYC);
                     st <= FSR_CY_RLOW;
                  end
               end
            end
            FSR_CY_WSET: begin
               fl_we_n_o <= 1'b0; // R4
               cnt <= 8'(`FSR_WP_CYC);
               st <= FSR_CY_WLOW;
            end
            FSR_CY_WLOW: begin
               if (cnt_done) begin
                  fl_we_n_o <= 1'b1; // R4
                  fl_ce_n_o <= 1'b1;
                  cnt <= 8'(`FSR_WPH_CYC);
                  st <= FSR_CY_GAP;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            FSR_CY_RLOW: begin
               if (cnt_done) begin
                  cyc.rdata <= fl_dq_i;
                  fl_ce_n_o <= 1'b1;
                  fl_oe_n_o <= 1'b1;
                  cnt <= 8'(`FSR_WPH_CYC);
                  st <= FSR_CY_GAP;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            FSR_CY_GAP: begin
               if (cnt_done) begin
                  fl_dq_oe_n_o <= 1'b1;
                  cyc.ack <= 1'b1;
                  st <= FSR_CY_IDLE;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            default: st <= FSR_CY_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_r4_pulse;
      @(posedge sys_clk_i) disable iff (srst_i)
      $fell(fl_we_n_o) |-> (!fl_we_n_o && !fl_ce_n_o && !fl_dq_oe_n_o) [*8];
   endproperty
   a_r4_pulse: assert property (p_r4_pulse) else $error("write pulse too short"); // R4
   property p_r4_within;
      @(posedge sys_clk_i) disable iff (srst_i)
      !fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o;
   endproperty
   a_r4_within: assert property (p_r4_within) else $error("write strobe outside select"); // R4
endmodule

// ==== hw/fsr_ctrl.sv ====
// Flash status and reset sequencer: AXI4-Lite registers driving a flash part.
// Assumes the flash pins are synchronous to sys_clk_i at 250 MHz.
//
// What the document requires
// R1: Device reports global engine ready on status bit 15.
// R2: Device reports addressed partition ready on status bit 7.
// R3: Partition flag may be 1 while another partition holds the engine.
// R4: A write spans the overlap of select low and write strobe low.
// R5: Device clears partition ready within access delay plus 50 ns.
// R6: After query or identifier reads the limit is access delay plus 100 ns.
// R7: Reset during program or erase completes within 22 us.
// R8: Reset with no operation running completes within 100 ns.
// R9: Outputs valid 150 ns after later of ready or reset release.
// R10: Host holds reset low at least 100 ns.
// R11: Program suspend sets partition ready within 10 us.
// R12: Erase suspend sets partition ready within 20 us.
// R13: Host leaves 500 us between erase resume and next suspend.
// R14: Host keeps program supply on until error bits read zero.
// R15: Host polls the global engine flag to detect completion.
// R16: Host holds reset low at least 100 ns at power-up.
// R17: Device erases main block within 5 s, parameter block within 4 s.
// R18: Device keeps returning status while busy until done, suspended or reset.
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "fsr_consts.svh"
module fsr_ctrl import fsr_pkg::*; #(
   parameter int ADDR_W = 22,
   parameter int ABORT_CYC = `FSR_ABORT_CYC,
   parameter int GAP_CYC = `FSR_ERES_CYC
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // AXI4-Lite write
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Flash pins
   output logic [ADDR_W-1:0] fl_addr_o,
   input wire logic [15:0] fl_dq_i,
   output logic [15:0] fl_dq_o,
   output logic fl_dq_oe_n_o,
   output logic fl_ce_n_o,
   output logic fl_we_n_o,
   output logic fl_oe_n_o,
   output logic fl_rst_n_o,
   output logic fl_vpp_en_o,
   // Interrupt
   output logic irq_o
);
   localparam int CNT_W = 17;

   function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
      hit = (a[5:2] == off[5:2]);
   endfunction

   fsr_cyc_if #(.ADDR_W(ADDR_W)) cyc();
   fsr_seq_st_t st;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] gap_cnt;
   logic [2:0] cmd_op;
   logic cmd_susp;
   logic cmd_res;
   logic start;
   logic [ADDR_W-1:0] fl_addr_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg;
   logic [15:0] sr;
   logic vpp_sw;
   logic vpp_hold;
   logic eng_busy;
   logic err_last;
   logic ev_done;
   logic ev_err;
   logic [1:0] irq_stat;
   logic [1:0] irq_en;
   logic [1:0] irq_clr;
   logic aw_got;
   logic w_got;
   logic [5:0] wa;
   logic [31:0] wd;

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   wire wr_fire = aw_got && w_got && !s_axi_bvalid;
   wire w_ctrl = hit(wa, `FSR_OFF_CTRL);
   wire w_addr = hit(wa, `FSR_OFF_ADDR);
   wire w_wdata = hit(wa, `FSR_OFF_WDATA);
   wire w_vpp = hit(wa, `FSR_OFF_VPP);
   wire w_clr = hit(wa, `FSR_OFF_IRQ_CLR);
   wire w_en = hit(wa, `FSR_OFF_IRQ_EN);
   wire w_ro = hit(wa, `FSR_OFF_RDATA) || hit(wa, `FSR_OFF_STATUS) || hit(wa, `FSR_OFF_IRQ_STAT);
   wire w_map = w_ctrl || w_addr || w_wdata || w_vpp || w_clr || w_en || w_ro;
   wire idle = (st == FSR_S_IDLE);
   wire [15:0] status_word = {10'h000, err_last, vpp_hold, sr[`FSR_SR_PART_BIT],
                              sr[`FSR_SR_GLOBAL_BIT], eng_busy, !idle};
   logic [31:0] rd_word;
   logic rd_map;

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_map = 1'b1;
      if (hit(s_axi_araddr, `FSR_OFF_CTRL)) begin
         rd_word = {26'h000_0000, cmd_res, cmd_susp, 1'b0, cmd_op};
      end else if (hit(s_axi_araddr, `FSR_OFF_ADDR)) begin
         rd_word = 32'(fl_addr_reg);
      end else if (hit(s_axi_araddr, `FSR_OFF_WDATA)) begin
         rd_word = {16'h0000, wdata_reg};
      end else if (hit(s_axi_araddr, `FSR_OFF_RDATA)) begin
         rd_word = {16'h0000, rdata_reg};
      end else if (hit(s_axi_araddr, `FSR_OFF_STATUS)) begin
         rd_word = {16'h0000, status_word};
      end else if (hit(s_axi_araddr, `FSR_OFF_VPP)) begin
         rd_word = {31'h0000_0000, vpp_sw};
      end else if (hit(s_axi_araddr, `FSR_OFF_IRQ_STAT)) begin
         rd_word = {30'h0000_0000, irq_stat};
      end else if (hit(s_axi_araddr, `FSR_OFF_IRQ_CLR)) begin
         rd_word = 32'h0000_0000;
      end else if (hit(s_axi_araddr, `FSR_OFF_IRQ_EN)) begin
         rd_word = {30'h0000_0000, irq_en};
      end else begin
         rd_map = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FSR_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `FSR_RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         wa <= 6'h00;
         wd <= 32'h0000_0000;
         cmd_op <= 3'h0;
         cmd_susp <= 1'b0;
         cmd_res <= 1'b0;
         start <= 1'b0;
         fl_addr_reg <= '0;
         wdata_reg <= 16'h0000;
         vpp_sw <= 1'b0;
         irq_en <= 2'h0;
         irq_clr <= 2'h0;
      end else begin
         s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_got;
         s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_got;
         start <= 1'b0;
         irq_clr <= 2'h0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            wa <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            wd <= s_axi_wdata;
         end
         if (wr_fire) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_map ? `FSR_RESP_OKAY : `FSR_RESP_SLVERR;
            if (w_ctrl && idle) begin
               cmd_op <= wd[`FSR_CTRL_OP_LSB +: 3];
               cmd_susp <= wd[`FSR_CTRL_SUSP_BIT];
               cmd_res <= wd[`FSR_CTRL_RES_BIT];
               start <= 1'b1;
            end else if (w_addr) begin
               fl_addr_reg <= wd[ADDR_W-1:0];
            end else if (w_wdata) begin
               wdata_reg <= wd[15:0];
            end else if (w_vpp) begin
               vpp_sw <= wd[0];
            end else if (w_clr) begin
               irq_clr <= wd[1:0];
            end else if (w_en) begin
               irq_en <= wd[1:0];
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_map ? `FSR_RESP_OKAY : `FSR_RESP_SLVERR;
         end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
            if (s_axi_rvalid && s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         irq_stat <= 2'h0;
         irq_o <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | {ev_err, ev_done};
         irq_o <= |(irq_stat & irq_en);
      end
   end

   // ----------------------------------------
   // Resume to suspend spacing
   // ----------------------------------------
   wire wr_ack = (st == FSR_S_WR) && cyc.ack;
   wire gap_load = wr_ack && cmd_res;
   wire sr_err = cyc.rdata[5] || cyc.rdata[4] || cyc.rdata[3] || cyc.rdata[1];
   wire sr_ready = cyc.rdata[`FSR_SR_GLOBAL_BIT];

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         gap_cnt <= '0;
      end else if (gap_load) begin
         gap_cnt <= CNT_W'(GAP_CYC); // R13
      end else if (gap_cnt != '0) begin
         gap_cnt <= gap_cnt - 1'b1;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st <= FSR_S_RSTLO;
         cnt <= CNT_W'(`FSR_RST_LOW_CYC); // R16
         fl_rst_n_o <= 1'b0;
         cyc.req <= 1'b0;
         cyc.wr <= 1'b0;
         cyc.addr <= '0;
         cyc.wdata <= 16'h0000;
         rdata_reg <= 16'h0000;
         sr <= 16'h0000;
         vpp_hold <= 1'b0;
         eng_busy <= 1'b0;
         err_last <= 1'b0;
         ev_done <= 1'b0;
         ev_err <= 1'b0;
         fl_vpp_en_o <= 1'b0;
      end else begin
         ev_done <= 1'b0;
         ev_err <= 1'b0;
         fl_vpp_en_o <= vpp_sw || vpp_hold; // R14
         case (st)
            FSR_S_RSTLO: begin
               if (cnt == '0) begin
                  fl_rst_n_o <= 1'b1; // R10
                  cnt <= CNT_W'(`FSR_PHQV_CYC);
                  st <= FSR_S_RSTREC;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            FSR_S_RSTREC: begin
               if (cnt == '0) begin
                  ev_done <= (cmd_op == FSR_OP_RESET); // R9
                  st <= FSR_S_IDLE;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            FSR_S_IDLE: begin
               cyc.addr <= fl_addr_reg;
               cyc.wdata <= wdata_reg;
               if (start) begin
                  if (cmd_op == FSR_OP_RESET) begin
                     fl_rst_n_o <= 1'b0;
                     cnt <= eng_busy ? CNT_W'(ABORT_CYC) : CNT_W'(`FSR_RST_LOW_CYC); // R7 R8
                     eng_busy <= 1'b0;
                     vpp_hold <= 1'b0;
                     st <= FSR_S_RSTLO;
                  end else if (cmd_op == FSR_OP_WRITE || cmd_op == FSR_OP_WRITE_POLL) begin
                     st <= FSR_S_GAPW;
                  end else if (cmd_op == FSR_OP_READ) begin
                     cyc.req <= 1'b1;
                     cyc.wr <= 1'b0;
                     st <= FSR_S_RD;
                  end else if (cmd_op == FSR_OP_POLL) begin
                     cnt <= '0;
                     st <= FSR_S_SETTLE;
                  end else begin
                     ev_done <= 1'b1;
                  end
               end
            end
            FSR_S_GAPW: begin
               if (!cmd_susp || gap_cnt == '0) begin // R13
                  cyc.req <= 1'b1;
                  cyc.wr <= 1'b1;
                  st <= FSR_S_WR;
               end
            end
            FSR_S_WR: begin
               if (cyc.ack) begin
                  cyc.req <= 1'b0;
                  eng_busy <= 1'b1; // R7
                  if (cmd_op == FSR_OP_WRITE_POLL) begin
                     vpp_hold <= 1'b1; // R14
                     cnt <= CNT_W'(`FSR_SETTLE_CYC); // R5 R6
                     st <= FSR_S_SETTLE;
                  end else begin
                     ev_done <= 1'b1;
                     st <= FSR_S_IDLE;
                  end
               end
            end
            FSR_S_SETTLE: begin
               if (cnt == '0) begin
                  cyc.req <= 1'b1;
                  cyc.wr <= 1'b0;
                  st <= FSR_S_POLL;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            FSR_S_POLL: begin
               if (cyc.ack) begin
                  cyc.req <= 1'b0;
                  sr <= cyc.rdata;
                  if (sr_ready) begin // R15
                     eng_busy <= 1'b0;
                     err_last <= sr_err;
                     vpp_hold <= vpp_hold && sr_err; // R14
                     ev_done <= 1'b1;
                     ev_err <= sr_err;
                     st <= FSR_S_IDLE;
                  end else begin
                     cnt <= '0; // R18
                     st <= FSR_S_SETTLE;
                  end
               end
            end
            FSR_S_RD: begin
               if (cyc.ack) begin
                  cyc.req <= 1'b0;
                  rdata_reg <= cyc.rdata;
                  ev_done <= 1'b1;
                  st <= FSR_S_IDLE;
               end
            end
            default: st <= FSR_S_IDLE;
         endcase
      end
   end

   fsr_cyc #(.ADDR_W(ADDR_W)) u_cyc (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .cyc(cyc.slave),
      .fl_addr_o(fl_addr_o),
      .fl_dq_i(fl_dq_i),
      .fl_dq_o(fl_dq_o),
      .fl_dq_oe_n_o(fl_dq_oe_n_o),
      .fl_ce_n_o(fl_ce_n_o),
      .fl_we_n_o(fl_we_n_o),
      .fl_oe_n_o(fl_oe_n_o)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [CNT_W-1:0] lo_cnt;
   logic [CNT_W-1:0] since_res;
   always_ff @(posedge sys_clk_i) begin
      lo_cnt <= (srst_i || fl_rst_n_o) ? '0 : lo_cnt + 1'b1;
      since_res <= srst_i ? '1 :
                   (gap_load ? '0 : ((&since_res) ? since_res : since_res + 1'b1));
   end
   sequence s_rst_hold;
      !fl_rst_n_o [*8];
   endsequence
   property p_r16;
      @(posedge sys_clk_i) disable iff (srst_i) $fell(srst_i) |-> s_rst_hold;
   endproperty
   a_r16: assert property (p_r16) else $error("reset not held after power-up"); // R16
   property p_r10;
      @(posedge sys_clk_i) disable iff (srst_i)
      $rose(fl_rst_n_o) |-> $past(lo_cnt) >= CNT_W'(`FSR_RST_LOW_CYC);
   endproperty
   a_r10: assert property (p_r10) else $error("reset pulse too short"); // R10
   property p_r13;
      @(posedge sys_clk_i) disable iff (srst_i)
      ($rose(cyc.req) && cyc.wr && cmd_susp) |-> since_res >= CNT_W'(GAP_CYC);
   endproperty
   a_r13: assert property (p_r13) else $error("suspend issued too soon"); // R13
   property p_r14;
      @(posedge sys_clk_i) disable iff (srst_i)
      $fell(vpp_hold) && $past(st == FSR_S_POLL) |-> $past(sr_ready && !sr_err);
   endproperty
   a_r14: assert property (p_r14) else $error("supply released before clean status"); // R14
   property p_r14_pin;
      @(posedge sys_clk_i) disable iff (srst_i) vpp_hold |=> fl_vpp_en_o;
   endproperty
   a_r14_pin: assert property (p_r14_pin) else $error("supply off while held"); // R14
   property p_r15;
      @(posedge sys_clk_i) disable iff (srst_i)
      (st == FSR_S_POLL && cyc.ack) |=> (st == FSR_S_IDLE) == $past(sr_ready);
   endproperty
   a_r15: assert property (p_r15) else $error("poll exit not on global flag"); // R15
endmodule

// ==== bench/fsr_flash_model.sv ====
// Behavioural flash part: status word, busy time after a write, reset abort.
// Assumes its pins are sampled on the controller clock.
`timescale 1ns/100ps
module fsr_flash_model #(
   parameter int BUSY_CYC = 200,
   parameter int SUSP_CYC = 20
) (
   input wire logic sys_clk_i,
   input wire logic ce_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic rst_n_i,
   output logic [15:0] dq_o
);
   int busy = 0;
   logic we_q = 1'h1;
   logic [15:0] last = 16'h0000;
   wire rdy = (busy == 0);
   wire rd_on = !oe_n_i && !ce_n_i;
   wire [15:0] status = {rdy, 7'h00, rdy, 7'h00};
   always @(posedge sys_clk_i) begin
      we_q <= we_n_i | ce_n_i;
      if (!rst_n_i)
         busy <= 0;
      else if (!we_q && (we_n_i | ce_n_i))
         busy <= (busy > 0) ? SUSP_CYC : BUSY_CYC;
      else if (busy > 0)
         busy <= busy - 1;
      if (rd_on)
         last <= status;
   end
   assign dq_o = rd_on ? status : ~last;
endmodule

// ==== bench/tb_fsr_ctrl.sv ====
// Testbench of the flash sequencer over AXI4-Lite.
// Assumes the flash model answers on the flash pins.
`timescale 1ns/100ps
`include "fsr_consts.svh"
module tb_fsr_ctrl import fsr_pkg::*; ;
   logic sys_clk_i = 1'h0, srst_i = 1'h1;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
   logic [21:0] fl_addr_o;
   logic [15:0] fl_dq_i, fl_dq_o;
   logic fl_dq_oe_n_o, fl_ce_n_o, fl_we_n_o, fl_oe_n_o, fl_rst_n_o, fl_vpp_en_o, irq_o;
   int errors = 0, n_checks = 0;
   always #2 sys_clk_i = ~sys_clk_i;
   fsr_ctrl #(.ABORT_CYC(30), .GAP_CYC(50)) u_dut (.*);
   fsr_flash_model u_flash (.sys_clk_i(sys_clk_i), .ce_n_i(fl_ce_n_o), .we_n_i(fl_we_n_o),
      .oe_n_i(fl_oe_n_o), .rst_n_i(fl_rst_n_o), .dq_o(fl_dq_i));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge sys_clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      chk(32'(s_axi_bresp), 32'(er));
   endtask
   task automatic rdv(input logic [5:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge sys_clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er);
      rdv(a);
      chk(rd_d, exp);
      chk(32'(rd_r), 32'(er));
   endtask
   task automatic idle();
      rdv(`FSR_OFF_STATUS);
      while (rd_d[0] !== 1'h0) rdv(`FSR_OFF_STATUS);
   endtask
   task automatic results();
      $display("Checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      errors++;
      results();
   end
   initial begin
      repeat (16) @(posedge sys_clk_i);
      srst_i <= 1'h0;
      rd(`FSR_OFF_IRQ_EN, 32'h0, `FSR_RESP_OKAY);
      rd(6'h3C, 32'h0, `FSR_RESP_SLVERR);
      wr(6'h3C, 32'h1, `FSR_RESP_SLVERR);
      idle();
      wr(`FSR_OFF_IRQ_EN, 32'h3, `FSR_RESP_OKAY);
      wr(`FSR_OFF_ADDR, 32'h100, `FSR_RESP_OKAY);
      wr(`FSR_OFF_WDATA, 32'hE8, `FSR_RESP_OKAY);
      wr(`FSR_OFF_CTRL, 32'h3, `FSR_RESP_OKAY);
      repeat (40) @(posedge sys_clk_i);
      chk(32'(fl_vpp_en_o), 32'h1);
      idle();
      chk(32'(fl_vpp_en_o), 32'h0);
      chk(32'(fl_addr_o), 32'h100);
      chk(32'(fl_dq_o), 32'hE8);
      chk(32'(fl_dq_oe_n_o), 32'h1);
      rd(`FSR_OFF_IRQ_STAT, 32'h1, `FSR_RESP_OKAY);
      chk(32'(irq_o), 32'h1);
      rd(`FSR_OFF_STATUS, 32'h0C, `FSR_RESP_OKAY);
      wr(`FSR_OFF_IRQ_CLR, 32'h1, `FSR_RESP_OKAY);
      rd(`FSR_OFF_IRQ_STAT, 32'h0, `FSR_RESP_OKAY);
      chk(32'(irq_o), 32'h0);
      wr(`FSR_OFF_CTRL, 32'h2, `FSR_RESP_OKAY);
      idle();
      rd(`FSR_OFF_RDATA, 32'h8080, `FSR_RESP_OKAY);
      wr(`FSR_OFF_CTRL, 32'h4, `FSR_RESP_OKAY);
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk(32'(fl_rst_n_o), 32'h0);
      @(posedge sys_clk_i);
      idle();
      chk(32'(fl_rst_n_o), 32'h1);
      rd(`FSR_OFF_IRQ_STAT, 32'h1, `FSR_RESP_OKAY);
      wr(`FSR_OFF_CTRL, 32'h21, `FSR_RESP_OKAY);
      idle();
      rd(`FSR_OFF_STATUS, 32'h0E, `FSR_RESP_OKAY);
      wr(`FSR_OFF_CTRL, 32'h11, `FSR_RESP_OKAY);
      repeat (10) @(posedge sys_clk_i);
      #1;
      chk(32'(fl_ce_n_o), 32'h1);
      @(posedge sys_clk_i);
      idle();
      wr(`FSR_OFF_CTRL, 32'h4, `FSR_RESP_OKAY);
      repeat (29) @(posedge sys_clk_i);
      #1;
      chk(32'(fl_rst_n_o), 32'h0);
      @(posedge sys_clk_i);
      idle();
      rd(`FSR_OFF_STATUS, 32'h0C, `FSR_RESP_OKAY);
      results();
   end
endmodule
